// File: inc/ash_pkg.sv
// Purpose: Constants, register map and types for the axis stop and halt command block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Fault codes are plain values chosen for this block.
// Notes on behaviour
// - Immediate stop starts on execute rising edge.
// - Deceleration and jerk come from the command.
// - Done asserts once axis speed is zero.
// - Busy holds until the command completes.
// - Any failure raises error with 16-bit code.
// - Immediate stop aborts others, enters stopping.
// - Stopping axis refuses every other command.
// - Stop aborted only by servo off/loss.
// - Stopping holds while execute high or moving.
// - Standstill after done with execute low.
// - Re-execute while busy reloads changed parameters.
// - Stop re-execute updates only deceleration, jerk.
// - Halt starts on its own execute edge.
// - Running halt reports the positioning state.
// - Halt reaching zero speed: done, standstill.
// - Halt takes a queue mode for sequencing.
// - New motion command preempts a running halt.
// - Halt active while it controls the axis.
// - Interrupted stop or halt asserts aborted.
// - Servo on: disabled to standstill, fail faults.
package ash_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] ASH_OFS_CTRL = 8'h00;
  localparam logic [7:0] ASH_OFS_AXIS = 8'h04;
  localparam logic [7:0] ASH_OFS_SDEC = 8'h08;
  localparam logic [7:0] ASH_OFS_SJRK = 8'h0C;
  localparam logic [7:0] ASH_OFS_HDEC = 8'h10;
  localparam logic [7:0] ASH_OFS_HJRK = 8'h14;
  localparam logic [7:0] ASH_OFS_STAT = 8'h18;
  localparam logic [7:0] ASH_OFS_FLT = 8'h1C;

  // Control register field positions.
  localparam int ASH_CTRL_STOP_EXE = 0;
  localparam int ASH_CTRL_HALT_EXE = 1;
  localparam int ASH_CTRL_SERVO_ON = 2;
  localparam int ASH_CTRL_QMODE_LO = 8;
  localparam int ASH_QMODE_W = 3;

  // Reset values.
  localparam logic [31:0] ASH_RST_WORD = 32'h0000_0000;
  localparam logic [15:0] ASH_RST_AXIS = 16'h0001;

  // Valid axis number ranges.
  localparam logic [15:0] ASH_AXIS_REAL_LO = 16'h0001;
  localparam logic [15:0] ASH_AXIS_REAL_HI = 16'h0020;
  localparam logic [15:0] ASH_AXIS_VIRT_LO = 16'h0025;
  localparam logic [15:0] ASH_AXIS_VIRT_HI = 16'h0028;

  // Queue mode that takes the axis at once.
  localparam logic [2:0] ASH_QMODE_ABORTING = 3'h0;

  // Fault codes.
  localparam logic [15:0] ASH_FLT_NONE = 16'h0000;
  localparam logic [15:0] ASH_FLT_AXIS = 16'h0001;
  localparam logic [15:0] ASH_FLT_LOCKED = 16'h0002;
  localparam logic [15:0] ASH_FLT_NOT_READY = 16'h0003;

  // Axis states, Gray coded along disabled, standstill, positioning, stopping.
  typedef enum logic [2:0] {
    ASH_DISABLED = 3'b000,
    ASH_STANDSTILL = 3'b001,
    ASH_POSITIONING = 3'b011,
    ASH_STOPPING = 3'b010,
    ASH_FAULT_HALT = 3'b110
  } ash_axis_state_t;

endpackage : ash_pkg

// File: rtl/ash_stop_halt.sv
// Purpose: Immediate stop and controlled halt command logic for one motion axis.
// Assumes: Profile generator reports zero speed; other motion blocks report start and busy.
// Notes: Execute inputs are register bits; edges are found against a delayed copy.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ash_stop_halt #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic speed_zero,
  input wire logic servo_ready,
  input wire logic servo_power_lost,
  input wire logic other_motion_start,
  input wire logic other_motion_busy,
  output ash_pkg::ash_axis_state_t axis_state,
  output logic decel_req,
  output logic [31:0] decel_rate,
  output logic [31:0] decel_jerk,
  output logic other_cmd_refused
);
  import ash_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Axis number check, used by both commands.
  function automatic logic axis_ok(input logic [15:0] n);
    axis_ok = ((n >= ASH_AXIS_REAL_LO) && (n <= ASH_AXIS_REAL_HI)) ||
              ((n >= ASH_AXIS_VIRT_LO) && (n <= ASH_AXIS_VIRT_HI));
  endfunction : axis_ok

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Software registers and command state.
  logic [31:0] ctrl_q, axis_q, sdec_q, sjrk_q, hdec_q, hjrk_q;
  logic stop_prev_q, halt_prev_q;
  ash_axis_state_t state_q, state_d;
  logic stop_busy_q, stop_busy_d, stop_done_q, stop_done_d;
  logic stop_abt_q, stop_abt_d, stop_err_q, stop_err_d;
  logic halt_busy_q, halt_busy_d, halt_act_q, halt_act_d, halt_done_q, halt_done_d;
  logic halt_abt_q, halt_abt_d, halt_err_q, halt_err_d;
  logic [15:0] stop_code_q, stop_code_d, halt_code_q, halt_code_d;
  logic [31:0] ws_dec_q, ws_dec_d, ws_jrk_q, ws_jrk_d, wh_dec_q, wh_dec_d, wh_jrk_q, wh_jrk_d;
  logic [2:0] wh_qm_q, wh_qm_d;
  logic refused_d;
  logic [31:0] prdata_q, rdata_sel;
  logic pready_q, pslverr_q, decel_req_q;
  logic [31:0] decel_rate_q, decel_jerk_q;
  logic refused_q;

  // Bus decode and request views.
  wire setup_ph = psel & ~penable;
  wire wr_take = psel & penable & pready_q & pwrite;
  wire [7:0] ofs = 8'(paddr);
  wire hit = (ofs[1:0] == 2'b00) && (ofs <= ASH_OFS_FLT);
  wire stop_exe = ctrl_q[ASH_CTRL_STOP_EXE];
  wire halt_exe = ctrl_q[ASH_CTRL_HALT_EXE];
  wire servo_on = ctrl_q[ASH_CTRL_SERVO_ON];
  wire [2:0] qmode = ctrl_q[ASH_CTRL_QMODE_LO +: ASH_QMODE_W];
  wire [15:0] stop_axis = axis_q[15:0];
  wire [15:0] halt_axis = axis_q[31:16];
  wire stop_rise = stop_exe & ~stop_prev_q;
  wire halt_rise = halt_exe & ~halt_prev_q;
  wire not_ready = (state_q == ASH_DISABLED) || (state_q == ASH_FAULT_HALT);
  wire stopping = state_q == ASH_STOPPING;
  wire servo_drop = servo_power_lost | (~servo_on & (state_q != ASH_DISABLED));
  wire stop_take = ~servo_drop & stop_rise & ~stop_busy_q & axis_ok(stop_axis) & ~not_ready;
  wire halt_lock = stopping | stop_take;
  wire halt_take = ~servo_drop & halt_rise & ~halt_busy_q & axis_ok(halt_axis) & ~not_ready &
                   ~halt_lock;
  wire other_ok = ~servo_drop & other_motion_start & ~halt_lock & ~not_ready;

  // Read data selection.
  assign rdata_sel =
    (ofs == ASH_OFS_CTRL) ? ctrl_q :
    (ofs == ASH_OFS_AXIS) ? axis_q :
    (ofs == ASH_OFS_SDEC) ? sdec_q :
    (ofs == ASH_OFS_SJRK) ? sjrk_q :
    (ofs == ASH_OFS_HDEC) ? hdec_q :
    (ofs == ASH_OFS_HJRK) ? hjrk_q :
    (ofs == ASH_OFS_STAT) ? {19'h0, state_q, 1'b0, halt_err_q, halt_abt_q, halt_act_q,
                             halt_busy_q, halt_done_q, stop_err_q, stop_abt_q, stop_busy_q,
                             stop_done_q} :
    (ofs == ASH_OFS_FLT) ? {halt_code_q, stop_code_q} : ASH_RST_WORD;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // APB answer: ready in the first access cycle, data captured in setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= ASH_RST_WORD;
    end else begin
      pready_q <= setup_ph;
      pslverr_q <= setup_ph & ~hit;
      prdata_q <= (setup_ph && !pwrite) ? rdata_sel : ASH_RST_WORD;
    end
  end

  // Writable registers; status and fault words ignore writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ASH_RST_WORD;
      axis_q <= {ASH_RST_AXIS, ASH_RST_AXIS};
      sdec_q <= ASH_RST_WORD;
      sjrk_q <= ASH_RST_WORD;
      hdec_q <= ASH_RST_WORD;
      hjrk_q <= ASH_RST_WORD;
    end else if (wr_take) begin
      if (ofs == ASH_OFS_CTRL) ctrl_q <= pwdata;
      if (ofs == ASH_OFS_AXIS) axis_q <= pwdata;
      if (ofs == ASH_OFS_SDEC) sdec_q <= pwdata;
      if (ofs == ASH_OFS_SJRK) sjrk_q <= pwdata;
      if (ofs == ASH_OFS_HDEC) hdec_q <= pwdata;
      if (ofs == ASH_OFS_HJRK) hjrk_q <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Command and axis state next values; servo loss wins, then the stop, then the halt.
  always_comb begin
    state_d = state_q;
    stop_busy_d = stop_busy_q;
    stop_done_d = stop_done_q;
    stop_abt_d = stop_abt_q;
    stop_err_d = stop_err_q;
    stop_code_d = stop_code_q;
    halt_busy_d = halt_busy_q;
    halt_act_d = halt_act_q;
    halt_done_d = halt_done_q;
    halt_abt_d = halt_abt_q;
    halt_err_d = halt_err_q;
    halt_code_d = halt_code_q;
    ws_dec_d = ws_dec_q;
    ws_jrk_d = ws_jrk_q;
    wh_dec_d = wh_dec_q;
    wh_jrk_d = wh_jrk_q;
    wh_qm_d = wh_qm_q;
    refused_d = 1'b0;
    // Flags drop once their execute is released after the command ended.
    if (!stop_exe && !stop_busy_q && !stopping) begin
      stop_done_d = 1'b0;
      stop_abt_d = 1'b0;
      stop_err_d = 1'b0;
      stop_code_d = ASH_FLT_NONE;
    end
    if (!halt_exe && !halt_busy_q) begin
      halt_done_d = 1'b0;
      halt_abt_d = 1'b0;
      halt_err_d = 1'b0;
      halt_code_d = ASH_FLT_NONE;
    end
    if (servo_drop) begin
      // Only servo loss or servo off can cut a running stop short.
      state_d = ASH_DISABLED;
      if (stop_busy_q) begin
        stop_abt_d = 1'b1;
        stop_busy_d = 1'b0;
      end
      if (halt_busy_q) begin
        halt_abt_d = 1'b1;
        halt_busy_d = 1'b0;
        halt_act_d = 1'b0;
      end
    end else begin
      if (state_q == ASH_DISABLED && servo_on) begin
        state_d = servo_ready ? ASH_STANDSTILL : ASH_FAULT_HALT;
      end
      // Immediate stop.
      if (stop_rise && stop_busy_q) begin
        ws_dec_d = sdec_q;
        ws_jrk_d = sjrk_q;
      end else if (stop_rise) begin
        stop_done_d = 1'b0;
        stop_abt_d = 1'b0;
        stop_err_d = 1'b0;
        stop_code_d = ASH_FLT_NONE;
        if (!axis_ok(stop_axis)) begin
          stop_err_d = 1'b1;
          stop_code_d = ASH_FLT_AXIS;
        end else if (not_ready) begin
          stop_err_d = 1'b1;
          stop_code_d = ASH_FLT_NOT_READY;
        end else begin
          stop_busy_d = 1'b1;
          ws_dec_d = sdec_q;
          ws_jrk_d = sjrk_q;
          state_d = ASH_STOPPING;
        end
      end else if (stop_busy_q && speed_zero) begin
        stop_busy_d = 1'b0;
        stop_done_d = 1'b1;
      end
      // Leaving the stopping state needs done and a released execute.
      if (stopping && stop_done_q && !stop_exe && speed_zero) begin
        state_d = ASH_STANDSTILL;
        stop_done_d = 1'b0;
      end
      // Controlled halt; a stop starting now takes the axis from it.
      if (stop_take && halt_busy_q) begin
        halt_abt_d = 1'b1;
        halt_busy_d = 1'b0;
        halt_act_d = 1'b0;
      end else if (halt_rise && halt_busy_q) begin
        wh_dec_d = hdec_q;
        wh_jrk_d = hjrk_q;
        wh_qm_d = qmode;
      end else if (halt_rise) begin
        halt_done_d = 1'b0;
        halt_abt_d = 1'b0;
        halt_err_d = 1'b0;
        halt_code_d = ASH_FLT_NONE;
        if (!axis_ok(halt_axis)) begin
          halt_err_d = 1'b1;
          halt_code_d = ASH_FLT_AXIS;
        end else if (halt_lock) begin
          halt_err_d = 1'b1;
          halt_code_d = ASH_FLT_LOCKED;
        end else if (not_ready) begin
          halt_err_d = 1'b1;
          halt_code_d = ASH_FLT_NOT_READY;
        end else begin
          halt_busy_d = 1'b1;
          wh_dec_d = hdec_q;
          wh_jrk_d = hjrk_q;
          wh_qm_d = qmode;
          if (qmode == ASH_QMODE_ABORTING || !other_motion_busy) begin
            halt_act_d = 1'b1;
            state_d = ASH_POSITIONING;
          end
        end
      end else if (halt_busy_q && other_ok) begin
        halt_abt_d = 1'b1;
        halt_busy_d = 1'b0;
        halt_act_d = 1'b0;
      end else if (halt_busy_q && !halt_act_q && !other_motion_busy && !halt_lock) begin
        halt_act_d = 1'b1;
        state_d = ASH_POSITIONING;
      end else if (halt_act_q && speed_zero && !halt_lock) begin
        halt_busy_d = 1'b0;
        halt_act_d = 1'b0;
        halt_done_d = 1'b1;
        state_d = ASH_STANDSTILL;
      end
      // Other motion commands: refused while stopping, else they own a ready axis.
      if (other_motion_start && halt_lock) begin
        refused_d = 1'b1;
      end else if (other_ok && !halt_take) begin
        state_d = ASH_POSITIONING;
      end else if (state_q == ASH_POSITIONING && !halt_busy_q && !halt_rise &&
                   !other_motion_busy && !other_motion_start && !stop_take) begin
        state_d = ASH_STANDSTILL;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Command state registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ASH_DISABLED;
      stop_prev_q <= 1'b0;
      halt_prev_q <= 1'b0;
      stop_busy_q <= 1'b0;
      stop_done_q <= 1'b0;
      stop_abt_q <= 1'b0;
      stop_err_q <= 1'b0;
      stop_code_q <= ASH_FLT_NONE;
      halt_busy_q <= 1'b0;
      halt_act_q <= 1'b0;
      halt_done_q <= 1'b0;
      halt_abt_q <= 1'b0;
      halt_err_q <= 1'b0;
      halt_code_q <= ASH_FLT_NONE;
    end else begin
      state_q <= state_d;
      stop_prev_q <= stop_exe;
      halt_prev_q <= halt_exe;
      stop_busy_q <= stop_busy_d;
      stop_done_q <= stop_done_d;
      stop_abt_q <= stop_abt_d;
      stop_err_q <= stop_err_d;
      stop_code_q <= stop_code_d;
      halt_busy_q <= halt_busy_d;
      halt_act_q <= halt_act_d;
      halt_done_q <= halt_done_d;
      halt_abt_q <= halt_abt_d;
      halt_err_q <= halt_err_d;
      halt_code_q <= halt_code_d;
    end
  end

  // Working parameter copies and profile outputs; the stop always overrides the halt.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ws_dec_q <= ASH_RST_WORD;
      ws_jrk_q <= ASH_RST_WORD;
      wh_dec_q <= ASH_RST_WORD;
      wh_jrk_q <= ASH_RST_WORD;
      wh_qm_q <= ASH_QMODE_ABORTING;
      decel_req_q <= 1'b0;
      decel_rate_q <= ASH_RST_WORD;
      decel_jerk_q <= ASH_RST_WORD;
      refused_q <= 1'b0;
    end else begin
      ws_dec_q <= ws_dec_d;
      ws_jrk_q <= ws_jrk_d;
      wh_dec_q <= wh_dec_d;
      wh_jrk_q <= wh_jrk_d;
      wh_qm_q <= wh_qm_d;
      decel_req_q <= stop_busy_d | halt_act_d;
      decel_rate_q <= stop_busy_d ? ws_dec_d : wh_dec_d;
      decel_jerk_q <= stop_busy_d ? ws_jrk_d : wh_jrk_d;
      refused_q <= refused_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign axis_state = state_q;
  assign decel_req = decel_req_q;
  assign decel_rate = decel_rate_q;
  assign decel_jerk = decel_jerk_q;
  assign other_cmd_refused = refused_q;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks on the command behaviour.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_stop_start;
    stop_take |=> stop_busy_q && state_q == ASH_STOPPING;
  endproperty
  a_stop_start: assert property (p_stop_start) else $error("stop not started");

  property p_stop_done;
    stop_busy_q && !stop_rise && !servo_drop && speed_zero |=> stop_done_q && !stop_busy_q;
  endproperty
  a_stop_done: assert property (p_stop_done) else $error("stop done missing");

  property p_stop_err_code;
    $rose(stop_err_q) |-> stop_code_q != ASH_FLT_NONE;
  endproperty
  a_stop_err_code: assert property (p_stop_err_code) else $error("no fault code");

  property p_lock;
    stopping && halt_rise && !halt_busy_q && !servo_drop |=> halt_err_q && !halt_busy_q;
  endproperty
  a_lock: assert property (p_lock) else $error("halt ran while stopping");

  property p_stop_hold;
    stopping && stop_exe && !servo_drop |=> state_q == ASH_STOPPING;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("left stopping early");

  property p_to_still;
    stopping && stop_done_q && !stop_exe && speed_zero && !servo_drop
      |=> state_q == ASH_STANDSTILL ##1 !stop_done_q || stop_rise;
  endproperty
  a_to_still: assert property (p_to_still) else $error("no standstill");

  property p_halt_pos;
    halt_act_q |-> state_q == ASH_POSITIONING;
  endproperty
  a_halt_pos: assert property (p_halt_pos) else $error("halt not positioning");

  property p_halt_preempt;
    halt_busy_q && other_ok && !halt_rise |=> halt_abt_q && !halt_busy_q;
  endproperty
  a_halt_preempt: assert property (p_halt_preempt) else $error("halt not aborted");

  property p_bad_axis;
    stop_rise && !stop_busy_q && !axis_ok(stop_axis) && !servo_drop && !halt_busy_q &&
      !halt_rise && !other_motion_start && !(state_q == ASH_DISABLED && servo_on) &&
      state_q != ASH_POSITIONING
      |=> stop_err_q && $stable(state_q);
  endproperty
  a_bad_axis: assert property (p_bad_axis) else $error("bad axis accepted");

endmodule : ash_stop_halt

`default_nettype wire

// File: tb/ash_axis_model.sv
// Purpose: Axis speed model that drives the zero-speed input of the block.
// Assumes: Speed falls only while the block asks for deceleration.
// Notes: The slow input stretches the ramp so long stops can be tested.
`timescale 1ns/1ps
`default_nettype none

module ash_axis_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic move,
  input wire logic slow,
  input wire logic decel_req,
  output logic speed_zero
);
  logic [7:0] spd_q;
  logic [7:0] spd_d;
  logic [7:0] step;

  // A move sets full speed; the ramp only runs under decel_req, so a dead request is seen.
  assign step = slow ? 8'h01 : 8'h40;
  assign spd_d = move ? 8'hFF : !decel_req ? spd_q : (spd_q > step) ? spd_q - step : 8'h00;
  assign speed_zero = (spd_q == 8'h00);

  // Speed register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spd_q <= 8'h00;
    end else begin
      spd_q <= spd_d;
    end
  end
endmodule : ash_axis_model

`default_nettype wire

// File: tb/testbench.sv
// Purpose: Self-checking bench for the axis stop and halt command block.
// Assumes: APB slave answers by pready; the axis model supplies zero speed.
// Notes: Status reads wait a few cycles so command effects have landed.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import ash_pkg::*;
  logic pclk;
  logic presetn, psel, penable, pwrite, pready, pslverr, err, seen;
  logic speed_zero, servo_ready, pwr_lost, om_start, om_busy, move, slow;
  logic decel_req, refused;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rate, jerk, rd;
  ash_axis_state_t st;
  int error_cnt = 0;
  int cmp_count = 0;

  //////////////////////////////////////////
  // Block under test and the axis model beside it.
  ash_stop_halt dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .speed_zero(speed_zero), .servo_ready(servo_ready), .servo_power_lost(pwr_lost),
    .other_motion_start(om_start), .other_motion_busy(om_busy), .axis_state(st),
    .decel_req(decel_req), .decel_rate(rate), .decel_jerk(jerk), .other_cmd_refused(refused)
  );
  ash_axis_model model_u (
    .pclk(pclk), .presetn(presetn), .move(move), .slow(slow), .decel_req(decel_req),
    .speed_zero(speed_zero)
  );

  // Free-running 20 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  //////////////////////////////////////////
  // Shared tasks.
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic finish_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // One transfer; the request holds until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, e);
  endtask : rdchk

  function automatic logic [31:0] sx(input logic [8:0] f, input ash_axis_state_t s);
    return {19'h0, s, 1'b0, f};
  endfunction : sx

  task automatic chk_st(input ash_axis_state_t e);
    repeat (3) @(posedge pclk);
    check({29'h0, st}, {29'h0, e});
  endtask : chk_st

  // Another motion command starts and sets the axis moving; seen records a refusal.
  task automatic pulse_om();
    seen = 1'b0;
    @(posedge pclk);
    om_start <= 1'b1;
    om_busy <= 1'b1;
    move <= 1'b1;
    @(posedge pclk);
    om_start <= 1'b0;
    move <= 1'b0;
    repeat (3) @(posedge pclk) seen = seen | refused;
  endtask : pulse_om

  task automatic wait_zero();
    while (speed_zero !== 1'b1) @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask : wait_zero

  //////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    check({29'h0, st}, {29'h0, ASH_DISABLED});
    rdchk(ASH_OFS_CTRL, ASH_RST_WORD);
    rdchk(ASH_OFS_AXIS, 32'h0001_0001);
    rdchk(ASH_OFS_STAT, sx(9'h000, ASH_DISABLED));
    rdchk(ASH_OFS_FLT, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    apb(1'b0, 8'h02, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    apb(1'b1, ASH_OFS_STAT, 32'hFFFF_FFFF);
    rdchk(ASH_OFS_STAT, sx(9'h000, ASH_DISABLED));
  endtask : t_reset

  task automatic t_servo();
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0004);
    chk_st(ASH_FAULT_HALT);
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0000);
    servo_ready <= 1'b1;
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0004);
    chk_st(ASH_STANDSTILL);
  endtask : t_servo

  task automatic t_stop();
    slow <= 1'b1;
    apb(1'b1, ASH_OFS_SDEC, 32'h0000_1234);
    apb(1'b1, ASH_OFS_SJRK, 32'h0000_0056);
    pulse_om();
    check({29'h0, st}, {29'h0, ASH_POSITIONING});
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0005);
    om_busy <= 1'b0;
    chk_st(ASH_STOPPING);
    check({rate[15:0], jerk[15:0]}, 32'h1234_0056);
    check({31'h0, decel_req}, 32'h0000_0001);
    rdchk(ASH_OFS_STAT, sx(9'h002, ASH_STOPPING));
    pulse_om();
    om_busy <= 1'b0;
    check({31'h0, seen}, 32'h0000_0001);
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0007);
    rdchk(ASH_OFS_FLT, 32'h0002_0000);
    apb(1'b1, ASH_OFS_SDEC, 32'h0000_0099);
    apb(1'b1, ASH_OFS_AXIS, 32'h0001_0021);
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0004);
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0005);
    chk_st(ASH_STOPPING);
    check(rate, 32'h0000_0099);
    rdchk(ASH_OFS_STAT, sx(9'h002, ASH_STOPPING));
    wait_zero();
    rdchk(ASH_OFS_STAT, sx(9'h001, ASH_STOPPING));
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0004);
    chk_st(ASH_STANDSTILL);
    rdchk(ASH_OFS_STAT, sx(9'h000, ASH_STANDSTILL));
    apb(1'b1, ASH_OFS_AXIS, 32'h0001_0001);
  endtask : t_stop

  task automatic t_halt();
    slow <= 1'b0;
    apb(1'b1, ASH_OFS_HDEC, 32'h0000_0777);
    apb(1'b1, ASH_OFS_HJRK, 32'h0000_0088);
    pulse_om();
    om_busy <= 1'b0;
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0006);
    repeat (2) @(posedge pclk);
    check({29'h0, st}, {29'h0, ASH_POSITIONING});
    check({rate[15:0], jerk[15:0]}, 32'h0777_0088);
    wait_zero();
    check({29'h0, st}, {29'h0, ASH_STANDSTILL});
    rdchk(ASH_OFS_STAT, sx(9'h010, ASH_STANDSTILL));
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0004);
    rdchk(ASH_OFS_STAT, sx(9'h000, ASH_STANDSTILL));
  endtask : t_halt

  task automatic t_preempt();
    slow <= 1'b1;
    pulse_om();
    om_busy <= 1'b0;
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0006);
    chk_st(ASH_POSITIONING);
    rdchk(ASH_OFS_STAT, sx(9'h060, ASH_POSITIONING));
    pulse_om();
    rdchk(ASH_OFS_STAT, sx(9'h080, ASH_POSITIONING));
    om_busy <= 1'b0;
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0004);
    chk_st(ASH_STANDSTILL);
  endtask : t_preempt

  task automatic t_queue();
    pulse_om();
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0106);
    rdchk(ASH_OFS_STAT, sx(9'h020, ASH_POSITIONING));
    om_busy <= 1'b0;
    rdchk(ASH_OFS_STAT, sx(9'h060, ASH_POSITIONING));
    wait_zero();
    rdchk(ASH_OFS_STAT, sx(9'h010, ASH_STANDSTILL));
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0004);
  endtask : t_queue

  task automatic t_power();
    apb(1'b1, ASH_OFS_AXIS, 32'h0001_0025);
    pulse_om();
    om_busy <= 1'b0;
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0005);
    chk_st(ASH_STOPPING);
    pwr_lost <= 1'b1;
    chk_st(ASH_DISABLED);
    rdchk(ASH_OFS_STAT, sx(9'h004, ASH_DISABLED));
    pwr_lost <= 1'b0;
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0000);
    apb(1'b1, ASH_OFS_CTRL, 32'h0000_0004);
    chk_st(ASH_STANDSTILL);
  endtask : t_power

  // Axis numbers just outside each valid range.
  task automatic t_axis();
    logic [15:0] bad [4];
    bad = '{16'h0000, 16'h0021, 16'h0024, 16'h0029};
    foreach (bad[i]) begin
      apb(1'b1, ASH_OFS_AXIS, {16'h0001, bad[i]});
      apb(1'b1, ASH_OFS_CTRL, 32'h0000_0005);
      chk_st(ASH_STANDSTILL);
      rdchk(ASH_OFS_STAT, sx(9'h008, ASH_STANDSTILL));
      rdchk(ASH_OFS_FLT, {16'h0000, ASH_FLT_AXIS});
      apb(1'b1, ASH_OFS_CTRL, 32'h0000_0004);
    end
  endtask : t_axis

  //////////////////////////////////////////
  // Main sequence; inputs start quiet and reset is held for four cycles.
  initial begin
    {presetn, psel, penable, pwrite, servo_ready, pwr_lost} = 6'h00;
    {om_start, om_busy, move, slow} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_servo();
    t_stop();
    t_halt();
    t_preempt();
    t_queue();
    t_power();
    t_axis();
    finish_test();
  end

  // Watchdog sized well above the several hundred cycles the scenarios need.
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    finish_test();
  end
endmodule : testbench

`default_nettype wire
